// [design/nps_protect.sv]
// flash / eeprom / ram protection and security block with axi4-lite registers
// assumes one bus clock, synchronous inputs, and image bytes valid at reset release
`timescale 1ns/1ps
module nps_protect (
  input  wire logic        aclk,               // bus clock, 40 MHz
  input  wire logic        aresetn,            // synchronous reset, active low
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,       // write address
  input  wire logic        s_axi_awvalid,      // write address valid
  output logic             s_axi_awready,      // write address ready
  input  wire logic [31:0] s_axi_wdata,        // write data
  input  wire logic [3:0]  s_axi_wstrb,        // write byte enables
  input  wire logic        s_axi_wvalid,       // write data valid
  output logic             s_axi_wready,       // write data ready
  output logic [1:0]       s_axi_bresp,        // write response
  output logic             s_axi_bvalid,       // write response valid
  input  wire logic        s_axi_bready,       // write response ready
  input  wire logic [7:0]  s_axi_araddr,       // read address
  input  wire logic        s_axi_arvalid,      // read address valid
  output logic             s_axi_arready,      // read address ready
  output logic [31:0]      s_axi_rdata,        // read data
  output logic [1:0]       s_axi_rresp,        // read response
  output logic             s_axi_rvalid,       // read data valid
  input  wire logic        s_axi_rready,       // read data ready
  // nonvolatile images seen at reset release
  input  wire logic [7:0]  protect_image_byte, // protection image
  input  wire logic [7:0]  option_image_byte,  // option image
  // background debug write path
  input  wire logic        dbg_prot_we,        // debug write strobe
  input  wire logic [7:0]  dbg_prot_data,      // debug write value
  // program / erase command path
  input  wire logic        cmd_valid,          // command offered
  input  wire logic [16:0] cmd_addr,           // command target
  input  wire logic        cmd_eeprom,         // target is eeprom
  output logic             cmd_ready,          // command accepted
  output logic             cmd_start,          // pulse: launch to array
  output logic             cmd_abort,          // pulse: refused as protected
  output logic [16:0]      cmd_start_addr,     // launched target
  output logic             cmd_start_eeprom,   // launched target is eeprom
  // interrupt vector fetch path
  input  wire logic        vec_req,            // vector fetch request
  input  wire logic [15:0] vec_addr,           // default vector address
  output logic             vec_ack,            // pulse: address ready
  output logic [15:0]      vec_addr_out,       // address to read
  output logic             vec_redirected,     // fetch was redirected
  // cpu / debug memory access gate
  input  wire logic        mem_req,            // access request
  input  wire logic        mem_we,             // access is a write
  input  wire logic [1:0]  mem_target,         // resource class
  input  wire logic        src_secure,         // code runs from secure memory
  input  wire logic        src_debug,          // access from debug port
  input  wire logic [7:0]  mem_rdata_in,       // data from the resource
  output logic             mem_ack,            // pulse: access done
  output logic             mem_we_out,         // pulse: write passed on
  output logic [7:0]       mem_rdata,          // read data to requester
  output logic             mem_blocked,        // access was blocked
  output logic             secure_engaged      // security active
);
  typedef struct packed {
    nps_pkg::nps_phase_t phase;
    logic [7:0]          prot;
    logic [7:0]          opt;
    logic                hold;
    logic                acc_err;
    logic                awready;
    logic                aw_held;
    logic [7:0]          aw_addr;
    logic                wready;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic                cmd_ready;
    logic                cmd_start;
    logic                cmd_abort;
    logic [16:0]         cmd_addr;
    logic                cmd_ee;
    logic                vec_ack;
    logic [15:0]         vec_addr;
    logic                vec_redir;
    logic                mem_ack;
    logic                mem_we;
    logic [7:0]          mem_rdata;
    logic                mem_blocked;
    logic                secure;
  } nps_state_t;

  localparam nps_state_t RESET_STATE = '0;

  nps_state_t st;
  nps_state_t next_st;

  logic [5:0]  flash_protect_size;
  logic [1:0]  eeprom_protect_size;
  logic        prot_hit;
  logic [15:0] remap_addr;
  logic        redirect_on;
  logic        sec_now;
  logic        running;
  logic        cmd_take;
  logic        wr_go;
  logic        clr_err;
  logic        set_err;
  logic        blk;
  logic [31:0] status_word;

  // size fields come from the working protection register only
  assign flash_protect_size     = st.prot[nps_pkg::FPS_LSB +: nps_pkg::FPS_W];
  assign eeprom_protect_size     = st.prot[nps_pkg::EPS_LSB +: nps_pkg::EPS_W];
  assign running = (st.phase == nps_pkg::PH_RUN);
  // anything but the open code counts as secured, so a blank image locks
  assign sec_now = (st.opt[nps_pkg::SEC_LSB +: nps_pkg::SEC_W] != nps_pkg::SEC_OPEN);

  nps_region_check #(
    .GRAN      (nps_pkg::FLASH_GRAN)
  ) u_region (
    .addr      (cmd_addr),
    .is_eeprom (cmd_eeprom),
    .flash_protect_size       (flash_protect_size),
    .eeprom_protect_size       (eeprom_protect_size),
    .hit       (prot_hit)
  );

  nps_vector_remap u_remap (
    .fetch_addr       (vec_addr),
    .flash_protect_size              (flash_protect_size),
    .redirect_disable (st.opt[nps_pkg::REDIR_DIS_BIT]),
    .remap_addr       (remap_addr),
    .redirect_on      (redirect_on)
  );

  // helper terms shared by the next-state logic
  assign cmd_take = cmd_valid && st.cmd_ready;
  assign wr_go    = st.aw_held && st.w_held && !st.bvalid;
  assign clr_err  = wr_go && (st.aw_addr == nps_pkg::OFS_STATUS) && st.w_strb[0]
                    && st.w_data[nps_pkg::ST_ACC_ERR];
  assign set_err  = running && cmd_take && prot_hit;
  // registers are never secure; flash, eeprom and ram are
  assign blk      = st.secure && (mem_target != 2'(nps_pkg::TGT_REGS))
                    && (!src_secure || src_debug);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[nps_pkg::ST_ACC_ERR] = st.acc_err;
    status_word[nps_pkg::ST_SECURE]  = st.secure;
    status_word[nps_pkg::ST_REDIR]   = redirect_on;
    status_word[nps_pkg::ST_LOADED]  = running;
  end

  // next state of the whole block
  always_comb begin
    next_st = st;

    // load phase: images captured once on the first edge after reset release
    case (st.phase)
      nps_pkg::PH_LOAD: begin
        next_st.prot  = protect_image_byte;
        next_st.opt   = option_image_byte;
        next_st.phase = nps_pkg::PH_RUN;
      end
      nps_pkg::PH_RUN: begin
        if (dbg_prot_we) begin
          next_st.prot = dbg_prot_data;
        end
      end
      default: begin
        next_st.phase = nps_pkg::PH_LOAD;
      end
    endcase
    next_st.secure = (next_st.phase == nps_pkg::PH_RUN) ? sec_now : 1'b1;

    // axi write address and data are held independently, either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = nps_pkg::RESP_OKAY;
      case (st.aw_addr)
        nps_pkg::OFS_PROT: begin
          // accepted but dropped so runaway code cannot unprotect
          next_st.bresp = nps_pkg::RESP_OKAY;
        end
        nps_pkg::OFS_OPT: begin
          next_st.bresp = nps_pkg::RESP_OKAY;
        end
        nps_pkg::OFS_STATUS: begin
          next_st.bresp = nps_pkg::RESP_OKAY;
        end
        nps_pkg::OFS_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.hold = st.w_data[nps_pkg::CTRL_HOLD];
          end
        end
        default: begin
          next_st.bresp = nps_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;

    // axi read: one cycle from address taken to data valid
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = nps_pkg::RESP_OKAY;
      case (s_axi_araddr)
        nps_pkg::OFS_PROT: begin
          next_st.rdata = {24'h000000, st.prot};
        end
        nps_pkg::OFS_OPT: begin
          next_st.rdata = {24'h000000, st.opt};
        end
        nps_pkg::OFS_STATUS: begin
          next_st.rdata = status_word;
        end
        nps_pkg::OFS_CTRL: begin
          next_st.rdata = {31'h00000000, st.hold};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = nps_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // sticky access error: a new violation wins over a same-cycle clear
    next_st.acc_err = (st.acc_err && !clr_err) || set_err;

    // program / erase commands: checked, then launched or aborted
    next_st.cmd_start = 1'b0;
    next_st.cmd_abort = 1'b0;
    if (running && cmd_take) begin
      next_st.cmd_addr = cmd_addr;
      next_st.cmd_ee   = cmd_eeprom;
      if (prot_hit) begin
        next_st.cmd_abort = 1'b1;
      end else begin
        next_st.cmd_start = 1'b1;
      end
    end
    // one idle cycle after each take keeps launches one pulse apart
    next_st.cmd_ready = (next_st.phase == nps_pkg::PH_RUN) && !next_st.hold && !cmd_take;

    // vector fetch translation, answered one cycle later
    next_st.vec_ack = running && vec_req;
    if (running && vec_req) begin
      next_st.vec_addr  = remap_addr;
      next_st.vec_redir = (remap_addr != vec_addr);
    end

    // memory access gate: blocked writes dropped, blocked reads give zero
    next_st.mem_ack = running && mem_req;
    next_st.mem_we  = running && mem_req && mem_we && !blk;
    if (running && mem_req) begin
      next_st.mem_blocked = blk;
      next_st.mem_rdata   = (blk || mem_we) ? 8'h00 : mem_rdata_in;
    end
  end

  // one register for the whole state; synchronous reset to constants
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready    = st.awready;
  assign s_axi_wready     = st.wready;
  assign s_axi_bvalid     = st.bvalid;
  assign s_axi_bresp      = st.bresp;
  assign s_axi_arready    = st.arready;
  assign s_axi_rvalid     = st.rvalid;
  assign s_axi_rresp      = st.rresp;
  assign s_axi_rdata      = st.rdata;
  assign cmd_ready        = st.cmd_ready;
  assign cmd_start        = st.cmd_start;
  assign cmd_abort        = st.cmd_abort;
  assign cmd_start_addr   = st.cmd_addr;
  assign cmd_start_eeprom = st.cmd_ee;
  assign vec_ack          = st.vec_ack;
  assign vec_addr_out     = st.vec_addr;
  assign vec_redirected   = st.vec_redir;
  assign mem_ack          = st.mem_ack;
  assign mem_we_out       = st.mem_we;
  assign mem_rdata        = st.mem_rdata;
  assign mem_blocked      = st.mem_blocked;
  assign secure_engaged   = st.secure;
endmodule // nps_protect

// [design/nps_region_check.sv]
// protected-region decode for program and erase targets
// assumes addresses in the 64K flash view or as eeprom offsets; purely combinational
`timescale 1ns/1ps
module nps_region_check #(
  parameter logic [16:0] GRAN = nps_pkg::FLASH_GRAN
) (
  input  wire logic [16:0] addr,      // target of program or erase
  input  wire logic        is_eeprom, // target lies in eeprom
  input  wire logic [5:0]  flash_protect_size,       // flash_protect_size
  input  wire logic [1:0]  eeprom_protect_size,       // eeprom_protect_size
  output logic             hit        // target is protected
);
  logic [16:0] flash_base;
  logic [12:0] ee_base;
  logic        flash_hit;
  logic        ee_hit;

  // image byte and vectors sit in the top granule, so any protection covers them
  if (nps_pkg::PROT_IMAGE_ADDR < nps_pkg::FLASH_END - GRAN ||
      {1'b0, nps_pkg::VEC_FIRST} < nps_pkg::FLASH_END - GRAN) begin : g_bad_gran
    $error("protection granule too small to cover image byte and vectors");
  end

  // region extent follows each size field; zero size protects nothing
  always_comb begin
    flash_base = nps_pkg::FLASH_END - 17'(17'(flash_protect_size) * GRAN);
    ee_base    = nps_pkg::EE_SIZE - 13'(13'(eeprom_protect_size) * nps_pkg::EE_GRAN);
    flash_hit  = (flash_protect_size != 6'h00) && (addr >= flash_base) && (addr <= nps_pkg::FLASH_TOP);
    ee_hit     = (eeprom_protect_size != 2'h0) && (addr[16:13] == 4'h0) && (addr[12:0] >= ee_base)
                 && (addr[12:0] < nps_pkg::EE_SIZE);
    hit        = is_eeprom ? ee_hit : flash_hit;
  end
endmodule // nps_region_check

// [design/nps_vector_remap.sv]
// interrupt vector redirection below the protected flash block
// assumes vector fetches are 16-bit cpu addresses; purely combinational
`timescale 1ns/1ps
module nps_vector_remap (
  input  wire logic [15:0] fetch_addr,       // vector fetch address
  input  wire logic [5:0]  flash_protect_size,              // flash_protect_size
  input  wire logic        redirect_disable, // vector_redirect_disable
  output logic [15:0]      remap_addr,       // address actually read
  output logic             redirect_on       // redirection armed
);
  logic        in_vec;
  logic [15:0] shift;

  // reset vector stays out of the window so a bad table can never brick boot
  always_comb begin
    redirect_on = !redirect_disable && (flash_protect_size != 6'h00);
    in_vec      = (fetch_addr >= nps_pkg::VEC_FIRST) && (fetch_addr <= nps_pkg::VEC_LAST);
    shift       = 16'(16'(flash_protect_size) * 16'(nps_pkg::FLASH_GRAN));
    remap_addr  = (redirect_on && in_vec) ? 16'(fetch_addr - shift) : fetch_addr;
  end
endmodule // nps_vector_remap

// [inc/nps_pkg.sv]
// constants, field layouts and types shared by the memory protection block
// assumes a single bus clock and a 17-bit flash / 13-bit eeprom address space
package nps_pkg;
  // register bus map, byte addresses of aligned 32-bit words
  localparam int          AXI_ADDR_W  = 8;
  localparam logic [7:0]  OFS_PROT    = 8'h00;
  localparam logic [7:0]  OFS_OPT     = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_CTRL    = 8'h0C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // protection byte layout
  localparam int FPS_LSB = 0;
  localparam int FPS_W   = 6;
  localparam int EPS_LSB = 6;
  localparam int EPS_W   = 2;

  // option byte layout; security is off only for the one open code
  localparam int          SEC_LSB       = 0;
  localparam int          SEC_W         = 2;
  localparam int          REDIR_DIS_BIT = 6;
  localparam logic [1:0]  SEC_OPEN      = 2'h2;

  // status and control bit positions
  localparam int ST_ACC_ERR = 0;
  localparam int ST_SECURE  = 1;
  localparam int ST_REDIR   = 2;
  localparam int ST_LOADED  = 3;
  localparam int CTRL_HOLD  = 0;

  // flash geometry: protected block grows down from the top of the 64K view
  localparam logic [16:0] FLASH_TOP       = 17'h0FFFF;
  localparam logic [16:0] FLASH_END       = 17'h10000;
  localparam logic [16:0] FLASH_GRAN      = 17'h00400;
  localparam logic [16:0] PROT_IMAGE_ADDR = 17'h0FFBD;
  localparam logic [15:0] VEC_FIRST       = 16'hFF80;
  localparam logic [15:0] VEC_LAST        = 16'hFFFD;

  // eeprom geometry: protected block grows down from the eeprom top
  localparam logic [12:0] EE_SIZE = 13'h1000;
  localparam logic [12:0] EE_GRAN = 13'h0100;

  typedef enum logic [1:0] {TGT_REGS, TGT_FLASH, TGT_EEPROM, TGT_RAM} nps_target_t;
  typedef enum logic {PH_LOAD, PH_RUN} nps_phase_t;
endpackage

// [tb/nps_flash_model.sv]
// flash array stand-in: nonvolatile image bytes, array read data, launch count
// assumes the bench programs the image bytes before each reset
`timescale 1ns/1ps
module nps_flash_model (
  input  wire logic        aclk,               // bus clock
  input  wire logic        cmd_start,          // launch from the block
  input  wire logic        nv_we,              // program the image bytes
  input  wire logic [15:0] nv_data,            // {protection, option}
  output logic [7:0]       protect_image_byte, // protection image
  output logic [7:0]       option_image_byte,  // option image
  output logic [7:0]       mem_rdata_in,       // array read data
  output int               n_prog              // launches seen
);
  // images only reach the block through its reset-time copy
  always @(posedge aclk) if (nv_we) {protect_image_byte, option_image_byte} <= nv_data;
  // read data moves every cycle so a stale sample cannot pass
  initial begin
    mem_rdata_in = 8'h5A;
    n_prog = 0;
  end
  always @(posedge aclk) mem_rdata_in <= mem_rdata_in + 8'h3B;
  always @(posedge aclk) if (cmd_start) n_prog <= n_prog + 1;
endmodule // nps_flash_model

// [tb/nps_protect_monitor.sv]
// concurrent checks on the command, vector and access gate ports
// assumes it is bound into nps_protect; one clock domain
`timescale 1ns/1ps
module nps_protect_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        cmd_start,
  input wire logic        cmd_abort,
  input wire logic        vec_req,
  input wire logic [15:0] vec_addr,
  input wire logic        vec_ack,
  input wire logic [15:0] vec_addr_out,
  input wire logic        vec_redirected,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [1:0]  mem_target,
  input wire logic        src_secure,
  input wire logic        src_debug,
  input wire logic [7:0]  mem_rdata_in,
  input wire logic        mem_ack,
  input wire logic        mem_we_out,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_blocked,
  input wire logic        secure_engaged
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a taken command answers exactly once and refuses the next cycle
  sequence cmd_take; cmd_valid && cmd_ready; endsequence
  sequence cmd_reply; (cmd_start ^ cmd_abort) && !cmd_ready; endsequence
  cmd_reply_a: assert property (cmd_take |=> cmd_reply)
    else $error("command not answered once");
  cmd_cause_a: assert property ((cmd_start || cmd_abort) |-> $past(cmd_valid && cmd_ready))
    else $error("command outcome without a take");
  // the gate: blocked accesses are silent, open ones pass through
  blocked_quiet_a: assert property (mem_blocked |-> mem_rdata == 8'h00 && !mem_we_out)
    else $error("blocked access leaked");
  regs_open_a: assert property (mem_req && mem_target == 2'h0 |=> mem_ack && !mem_blocked)
    else $error("register access blocked");
  secure_src_a: assert property (mem_req && src_secure && !src_debug |=> !mem_blocked)
    else $error("secure code blocked");
  pass_read_a: assert property (mem_req && !mem_we && src_secure && !src_debug
    |=> mem_rdata == $past(mem_rdata_in)) else $error("read data not passed");
  unsecured_a: assert property (mem_req && !secure_engaged |=> !mem_blocked)
    else $error("blocked while open");
  // vector fetches: reset vector and low addresses go straight through
  reset_vec_a: assert property (vec_req && vec_addr > 16'hFFFD
    |=> vec_ack && !vec_redirected && vec_addr_out == $past(vec_addr)) else $error("reset vector moved");
  low_vec_a: assert property (vec_req && vec_addr < 16'hFF80 |=> vec_addr_out == $past(vec_addr))
    else $error("non-vector address moved");
  redir_offset_a: assert property (vec_ack && vec_redirected
    |-> vec_addr_out[9:0] == $past(vec_addr[9:0]) && vec_addr_out < 16'hFF80) else $error("bad offset");
endmodule // nps_protect_monitor

// [tb/tb_nvm_protection_security.sv]
// self-checking bench: image configs, register bus, commands, vectors, access gate
// assumes the flash model supplies images and read data; checker bound at the foot
`timescale 1ns/1ps
module tb_nvm_protection_security;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dbg_prot_we;
  logic cmd_valid, cmd_eeprom, cmd_ready, cmd_start, cmd_abort, cmd_start_eeprom, nv_we;
  logic vec_req, vec_ack, vec_redirected, mem_req, mem_we, src_secure, src_debug;
  logic mem_ack, mem_we_out, mem_blocked, secure_engaged, any_abort;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mem_target;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, protect_image_byte, option_image_byte, prot, opt;
  logic [7:0]  dbg_prot_data, mem_rdata_in, mem_rdata;
  logic [15:0] vec_addr, vec_addr_out, nv_data;
  logic [16:0] cmd_addr, cmd_start_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h0000000F;
  int          n_errors = 0, n_tests = 0, n_prog, n_launch;
  nps_protect DUT (.*);
  nps_flash_model u_flash (.*);
  // 40 MHz bus clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected protection hit from the working protection byte
  function automatic logic exp_hit(input logic [16:0] a, input logic ee);
    if (ee) return prot[7:6] != 2'h0 && int'(a) >= 4096 - 256 * prot[7:6];
    return prot[5:0] != 6'h00 && a < 17'h10000 && int'(a) >= 65536 - 1024 * prot[5:0];
  endfunction
  function automatic logic [15:0] exp_vec(input logic [15:0] a);
    if (!opt[6] && prot[5:0] != 6'h00 && a >= 16'hFF80 && a <= 16'hFFFD)
      return a - {prot[5:0], 10'h000};
    return a;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic stuck();
    n_errors++;
    $display("BAD handshake expected done seen timeout");
    complete_run();
  endtask
  // register bus master: hold each channel until its ready, wait for the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    for (i = 0; i < 30; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 30) stuck();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (i = 0; i < 30; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 30) stuck();
  endtask
  // program the images, then reset for 4 cycles so the block copies them
  task automatic restart(input logic [7:0] p, input logic [7:0] o);
    @(posedge aclk);
    nv_we <= 1'b1; nv_data <= {p, o};
    @(posedge aclk);
    nv_we <= 1'b0; aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    prot = p; opt = o; n_launch = n_prog; any_abort = 1'b0;
  endtask
  task automatic cmd_op(input logic [16:0] a, input logic ee);
    int i = 0;
    logic hit;
    hit = exp_hit(a, ee);
    @(posedge aclk);
    cmd_valid <= 1'b1; cmd_addr <= a; cmd_eeprom <= ee;
    do begin @(posedge aclk); i++; end while (!cmd_ready && i < 20);
    cmd_valid <= 1'b0;
    if (i == 20) stuck();
    #1;
    chk("abort", hit, cmd_abort);
    chk("start", !hit, cmd_start);
    chk("start tgt", {ee, a}, {cmd_start_eeprom, cmd_start_addr});
    if (!hit) n_launch++;
    any_abort |= hit;
  endtask
  task automatic vec_op(input logic [15:0] v);
    @(posedge aclk);
    vec_req <= 1'b1; vec_addr <= v;
    @(posedge aclk);
    vec_req <= 1'b0;
    #1;
    chk("vec addr", {1'b1, exp_vec(v)}, {vec_ack, vec_addr_out});
    chk("vec moved", exp_vec(v) != v, vec_redirected);
  endtask
  task automatic mem_op(input logic [4:0] k);
    logic [7:0] d;
    logic blk;
    @(posedge aclk);
    mem_req <= 1'b1; mem_target <= k[1:0]; mem_we <= k[2]; src_secure <= k[3]; src_debug <= k[4];
    @(posedge aclk);
    d = mem_rdata_in;
    mem_req <= 1'b0;
    #1;
    blk = opt[1:0] != nps_pkg::SEC_OPEN && k[1:0] != 2'h0 && (!k[3] || k[4]);
    chk("mem blk", {1'b1, blk}, {mem_ack, mem_blocked});
    chk("mem we", k[2] && !blk, mem_we_out);
    chk("mem rd", (k[2] || blk) ? 8'h00 : d, mem_rdata);
  endtask
  logic [15:0] vl [6] = '{16'hFF80, 16'hFFE0, 16'hFFFD, 16'hFFFE, 16'hFFFF, 16'hFF7F};
  task automatic run_cfg(input logic [7:0] p, input logic [7:0] o);
    logic [31:0] d, r32;
    logic [1:0] r;
    logic [16:0] a;
    restart(p, o);
    axi_rd(nps_pkg::OFS_PROT, d, r); chk("prot", {24'h0, p}, d);
    axi_rd(nps_pkg::OFS_OPT, d, r); chk("opt", {24'h0, o}, d);
    axi_rd(nps_pkg::OFS_STATUS, d, r);
    chk("status", {28'h1, !o[6] && p[5:0] != 6'h0, o[1:0] != nps_pkg::SEC_OPEN, 1'b0}, d);
    chk("secure", o[1:0] != nps_pkg::SEC_OPEN, secure_engaged);
    axi_wr(nps_pkg::OFS_PROT, {24'h0, ~p}, r); chk("wr resp", nps_pkg::RESP_OKAY, r);
    axi_rd(nps_pkg::OFS_PROT, d, r); chk("prot kept", {24'h0, p}, d);
    axi_rd(8'h10, d, r); chk("unmapped", {nps_pkg::RESP_SLVERR, 30'h0}, {r, d[29:0]});
    for (int k = 0; k < 14; k++) begin
      r32 = rnd();
      case (k)
        0: a = 17'h10000 - {p[5:0], 10'h000};
        1: a = 17'h0FFFF - {p[5:0], 10'h000};
        2: a = nps_pkg::PROT_IMAGE_ADDR;
        3: a = 17'h0FFFE;
        4: a = 17'h10000;
        5: a = 17'h01000 - {p[7:6], 8'h00};
        6: a = 17'h00FFF - {p[7:6], 8'h00};
        default: a = (k > 10) ? {5'h00, r32[11:0]} : {1'b0, r32[15:0]};
      endcase
      cmd_op(a, k == 5 || k == 6 || k > 10);
    end
    axi_rd(nps_pkg::OFS_STATUS, d, r); chk("acc err", any_abort, d[0]);
    chk("launches", n_launch, n_prog);
    axi_wr(nps_pkg::OFS_STATUS, 32'h1, r);
    axi_rd(nps_pkg::OFS_STATUS, d, r); chk("acc clr", 1'b0, d[0]);
    foreach (vl[i]) vec_op(vl[i]);
    vec_op(16'(rnd()) | 16'hFF00);
    for (int k = 0; k < 32; k++) mem_op(k[4:0]);
    $display("config %h %h finished", p, o);
  endtask
  // main sequence: fixed corner configs, one random config, then a debug write
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {dbg_prot_we, cmd_valid, cmd_eeprom, vec_req, mem_req, mem_we, src_secure, src_debug} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, dbg_prot_data, cmd_addr} = '0;
    {vec_addr, mem_target, nv_data, nv_we} = '0;
    run_cfg(8'h08, 8'h02);
    run_cfg(8'hC3, 8'h00);
    run_cfg(8'h00, 8'h42);
    run_cfg(8'h7F, 8'h43);
    run_cfg(8'h41, 8'h01);
    d = rnd();
    run_cfg(d[7:0], d[15:8] & 8'h43);
    restart(8'h20, 8'h00);
    @(posedge aclk);
    dbg_prot_we <= 1'b1; dbg_prot_data <= 8'h01;
    @(posedge aclk);
    dbg_prot_we <= 1'b0;
    prot = 8'h01;
    axi_rd(nps_pkg::OFS_PROT, d, r); chk("dbg prot", 32'h1, d);
    cmd_op(17'h09000, 1'b0);
    cmd_op(17'h0FC00, 1'b0);
    vec_op(16'hFFE0);
    axi_wr(nps_pkg::OFS_CTRL, 32'h1, r);
    axi_rd(nps_pkg::OFS_CTRL, d, r);
    chk("hold", 2'h2, {d[0], cmd_ready});
    $display("debug write finished");
    complete_run();
  end
endmodule // tb_nvm_protection_security
bind nps_protect nps_protect_monitor u_mon (.*);
